/* design/pec_pkg.sv */
/*
  package for the event counter block: register offsets, field positions,
  control encodings and the packed structs that group the
  event inputs and the block state.
  assumes an axi4-lite master with 32-bit data and one core clock.
*/
// Functional notes
// R01: three counters packed in one 64-bit register
// R02: counter a control: off, count, irq 65536/256
// R03: counter b control uses same four encodings
// R04: counter c control: off, count, irq 16384/256
// R05: counter a select: cycles or issued instructions
// R06: user inhibit stops counting in user mode
// R07: privlib inhibit stops counting in privileged library mode
// R08: os inhibit kills kernel/exec/super; all three: kernel only
// R09: counter b codes 0-7 pick issue-cycle events
// R10: counter b codes 9-f pick ops, caches, bus input
// R11: counter b code 8 depends on counter c select
// R12: counter c codes 0-7 map stalls, mispredicts, misses
// R13: counter c codes 8-f map merges, replays, cycles, bus
// R14: any select mix legal; only code 8 couples
// R15: pending irqs shown at summary bits 27..29
// R16: master enable clear disables all counters
// R17: write one to clear register drops request
// R18: counters increment per event, wrap, latch irq
// R19: software write loads everything, beats increments
package pec_pkg;
  // byte offsets: counter register low/high words, then own registers
  localparam logic [11:0] PEC_CTR_LO_OFF = 12'h11c;
  localparam logic [11:0] PEC_CTR_HI_OFF = 12'h120;
  localparam logic [11:0] PEC_SUMMARY_OFF = 12'h124;
  localparam logic [11:0] PEC_CLEAR_OFF = 12'h128;
  localparam logic [11:0] PEC_MASK_OFF = 12'h12c;
  localparam logic [11:0] PEC_MASTER_OFF = 12'h130;
  // field positions inside the 64-bit counter register
  localparam int PEC_A_LSB = 48;
  localparam int PEC_B_LSB = 32;
  localparam int PEC_SELA_BIT = 31;
  localparam int PEC_KU_BIT = 30;
  localparam int PEC_C_LSB = 16;
  localparam int PEC_CTLA_LSB = 14;
  localparam int PEC_CTLB_LSB = 12;
  localparam int PEC_CTLC_LSB = 10;
  localparam int PEC_KP_BIT = 9;
  localparam int PEC_KK_BIT = 8;
  localparam int PEC_SELB_LSB = 4;
  localparam int PEC_SELC_LSB = 0;
  // summary / clear bit positions
  localparam int PEC_IRQ_LSB = 27;
  localparam logic [4:0] PEC_IRQ_IPL = 5'h1d;
  // control encodings
  localparam logic [1:0] PEC_CTL_OFF = 2'h0;
  localparam logic [1:0] PEC_CTL_CNT = 2'h1;
  localparam logic [1:0] PEC_CTL_FULL = 2'h2;
  localparam logic [1:0] PEC_CTL_256 = 2'h3;
  // counter c selects that couple counter b code 8
  localparam logic [3:0] PEC_SELC_PCM = 4'h2;
  localparam logic [3:0] PEC_SELC_BRM = 4'h3;
  localparam logic [3:0] PEC_SELB_FLOW = 4'h8;
  // processor modes
  typedef enum logic [2:0] {
    PEC_MODE_KERNEL = 3'b000,
    PEC_MODE_EXEC = 3'b001,
    PEC_MODE_SUPER = 3'b010,
    PEC_MODE_USER = 3'b011,
    PEC_MODE_PRIVLIB = 3'b100
  } pec_mode_t;
  // per-cycle event pulses from the pipeline and bus unit
  typedef struct packed {
    logic instr_issued;
    logic non_issue;
    logic split_issue;
    logic pipe_dry;
    logic replay_trap;
    logic [2:0] issue_count;   // instructions issued this cycle, 0..4
    logic jsr_ret;
    logic cond_branch;
    logic flow_change;
    logic int_op;
    logic fp_op;
    logic load;
    logic store;
    logic icache_issue;
    logic dcache_access;
    logic long_stall;
    logic pc_mispredict;
    logic br_mispredict;
    logic icache_miss;
    logic itb_miss;
    logic dcache_ld_miss;
    logic dtb_miss;
    logic ld_merged;
    logic ldu_replay;
    logic wb_full_replay;
    logic mb_stall;
    logic ld_locked;
    logic [1:0] bus_unit;
  } pec_events_t;
  // axi slave phases
  typedef enum logic [1:0] {
    PEC_W_IDLE = 2'b00,
    PEC_W_RESP = 2'b01
  } pec_wph_t;
  // whole block state
  typedef struct packed {
    logic [15:0] cnt_a;
    logic [15:0] cnt_b;
    logic [13:0] cnt_c;
    logic sel_a;
    logic inh_user;
    logic inh_privlib;
    logic inh_os;
    logic [1:0] ctl_a;
    logic [1:0] ctl_b;
    logic [1:0] ctl_c;
    logic [3:0] sel_b;
    logic [3:0] sel_c;
    logic [2:0] pend;          // sticky irq status
    logic [2:0] mask;
    logic [1:0] master_en;
    logic irq;
    logic aw_got;
    logic [11:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    pec_wph_t wph;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } pec_state_t;
endpackage : pec_pkg

/* design/pec_top.sv */
/*
  event counter block: three counters with selects, controls, mode
  inhibits, sticky irq status and an axi4-lite register slave.
  assumes event inputs and cpu_mode synchronous to core_clk, one pulse
  per event per cycle.
*/
`timescale 1ns/10ps
module pec_top (
  input wire logic core_clk,
  input wire logic resetn,
  input wire pec_pkg::pec_events_t events,
  input wire pec_pkg::pec_mode_t cpu_mode,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq
);
  pec_pkg::pec_state_t st_reg; // all state
  pec_pkg::pec_state_t st_next;
  logic [63:0] ctr_word; // assembled counter register
  logic [31:0] summary; // read-only summary word
  logic count_ok; // mode and master gating
  logic ev_a, ev_b, ev_c; // selected events this cycle
  logic [2:0] hit; // threshold crossings
  logic do_write; // both write halves held
  logic [31:0] wr_val; // byte-merged write value
  logic [31:0] cur_val; // current value at write address

  // assemble the 64-bit counter register view
  always_comb begin
    ctr_word = '0;
    ctr_word[63:48] = st_reg.cnt_a; // R01
    ctr_word[47:32] = st_reg.cnt_b; // R01
    ctr_word[pec_pkg::PEC_SELA_BIT] = st_reg.sel_a;
    ctr_word[pec_pkg::PEC_KU_BIT] = st_reg.inh_user;
    ctr_word[29:16] = st_reg.cnt_c; // R01
    ctr_word[15:14] = st_reg.ctl_a;
    ctr_word[13:12] = st_reg.ctl_b;
    ctr_word[11:10] = st_reg.ctl_c;
    ctr_word[pec_pkg::PEC_KP_BIT] = st_reg.inh_privlib;
    ctr_word[pec_pkg::PEC_KK_BIT] = st_reg.inh_os;
    ctr_word[7:4] = st_reg.sel_b;
    ctr_word[3:0] = st_reg.sel_c;
    summary = '0;
    summary[29:27] = st_reg.pend; // R15
  end

  // mode inhibits; all three set means only exec and super still count
  always_comb begin
    count_ok = 1'b1;
    unique case (cpu_mode)
      pec_pkg::PEC_MODE_USER: count_ok = !st_reg.inh_user; // R06
      pec_pkg::PEC_MODE_PRIVLIB: count_ok = !st_reg.inh_privlib; // R07
      pec_pkg::PEC_MODE_KERNEL: count_ok = !st_reg.inh_os; // R08
      pec_pkg::PEC_MODE_EXEC, pec_pkg::PEC_MODE_SUPER: begin
        // R08
        count_ok = !(st_reg.inh_os && !(st_reg.inh_user && st_reg.inh_privlib));
      end
      default: count_ok = 1'b0; // illegal mode code: do not count
    endcase
    if (st_reg.master_en == 2'b00) begin
      count_ok = 1'b0; // R16
    end
  end

  // event selection muxes
  always_comb begin
    ev_a = st_reg.sel_a ? events.instr_issued : 1'b1; // R05
    ev_b = 1'b0;
    unique case (st_reg.sel_b)
      4'h0: ev_b = events.non_issue; // R09
      4'h1: ev_b = events.split_issue;
      4'h2: ev_b = events.pipe_dry;
      4'h3: ev_b = events.replay_trap;
      4'h4: ev_b = (events.issue_count == 3'h1);
      4'h5: ev_b = (events.issue_count == 3'h2);
      4'h6: ev_b = (events.issue_count == 3'h3);
      4'h7: ev_b = (events.issue_count == 3'h4);
      4'h8: begin
        // coupling to counter c select, the only one
        if (st_reg.sel_c == pec_pkg::PEC_SELC_PCM) ev_b = events.jsr_ret; // R11 R14
        else if (st_reg.sel_c == pec_pkg::PEC_SELC_BRM) ev_b = events.cond_branch; // R11
        else ev_b = events.flow_change; // R11
      end
      4'h9: ev_b = events.int_op; // R10
      4'ha: ev_b = events.fp_op;
      4'hb: ev_b = events.load;
      4'hc: ev_b = events.store;
      4'hd: ev_b = events.icache_issue;
      4'he: ev_b = events.dcache_access;
      4'hf: ev_b = events.bus_unit[0];
    endcase
    ev_c = 1'b0;
    unique case (st_reg.sel_c)
      4'h0: ev_c = events.long_stall; // R12
      4'h1: ev_c = 1'b0; // reserved code counts nothing
      4'h2: ev_c = events.pc_mispredict;
      4'h3: ev_c = events.br_mispredict;
      4'h4: ev_c = events.icache_miss;
      4'h5: ev_c = events.itb_miss;
      4'h6: ev_c = events.dcache_ld_miss;
      4'h7: ev_c = events.dtb_miss;
      4'h8: ev_c = events.ld_merged; // R13
      4'h9: ev_c = events.ldu_replay;
      4'ha: ev_c = events.wb_full_replay;
      4'hb: ev_c = 1'b0; // reserved
      4'hc: ev_c = 1'b1;
      4'hd: ev_c = events.mb_stall;
      4'he: ev_c = events.ld_locked;
      4'hf: ev_c = events.bus_unit[1];
    endcase
  end

  // write value merge with byte strobes
  always_comb begin
    cur_val = '0;
    unique case (st_reg.aw_addr)
      pec_pkg::PEC_CTR_LO_OFF: cur_val = ctr_word[31:0];
      pec_pkg::PEC_CTR_HI_OFF: cur_val = ctr_word[63:32];
      pec_pkg::PEC_MASK_OFF: cur_val = {29'h0, st_reg.mask};
      pec_pkg::PEC_MASTER_OFF: cur_val = {30'h0, st_reg.master_en};
      default: cur_val = '0;
    endcase
    for (int i = 0; i < 4; i++) begin
      wr_val[i*8 +: 8] = st_reg.w_strb[i] ? st_reg.w_data[i*8 +: 8] : cur_val[i*8 +: 8];
    end
  end

  assign do_write = st_reg.aw_got && st_reg.w_got && st_reg.wph == pec_pkg::PEC_W_IDLE;

  // next-state: counting, register writes, bus handshakes
  always_comb begin
    st_next = st_reg;
    hit = 3'b000;
    // counters advance and wrap; irq at threshold crossing
    if (count_ok && st_reg.ctl_a != pec_pkg::PEC_CTL_OFF && ev_a) begin
      st_next.cnt_a = st_reg.cnt_a + 16'h0001; // R18 R02
      hit[0] = (st_reg.ctl_a == pec_pkg::PEC_CTL_FULL && st_reg.cnt_a == 16'hffff) ||
               (st_reg.ctl_a == pec_pkg::PEC_CTL_256 && st_reg.cnt_a[7:0] == 8'hff);
    end
    if (count_ok && st_reg.ctl_b != pec_pkg::PEC_CTL_OFF && ev_b) begin
      st_next.cnt_b = st_reg.cnt_b + 16'h0001; // R18 R03
      hit[1] = (st_reg.ctl_b == pec_pkg::PEC_CTL_FULL && st_reg.cnt_b == 16'hffff) ||
               (st_reg.ctl_b == pec_pkg::PEC_CTL_256 && st_reg.cnt_b[7:0] == 8'hff);
    end
    if (count_ok && st_reg.ctl_c != pec_pkg::PEC_CTL_OFF && ev_c) begin
      st_next.cnt_c = st_reg.cnt_c + 14'h0001; // R18 R04
      hit[2] = (st_reg.ctl_c == pec_pkg::PEC_CTL_FULL && st_reg.cnt_c == 14'h3fff) ||
               (st_reg.ctl_c == pec_pkg::PEC_CTL_256 && st_reg.cnt_c[7:0] == 8'hff);
    end
    // write channel capture
    if (s_axi_awvalid && !st_reg.aw_got) begin
      st_next.aw_got = 1'b1;
      st_next.aw_addr = {s_axi_awaddr[11:2], 2'b00};
    end
    if (s_axi_wvalid && !st_reg.w_got) begin
      st_next.w_got = 1'b1;
      st_next.w_data = s_axi_wdata;
      st_next.w_strb = s_axi_wstrb;
    end
    if (do_write) begin
      st_next.bvalid = 1'b1;
      st_next.bresp = 2'b00;
      st_next.wph = pec_pkg::PEC_W_RESP;
      unique case (st_reg.aw_addr)
        pec_pkg::PEC_CTR_LO_OFF: begin
          // software load overrides increments this cycle
          st_next.sel_a = wr_val[pec_pkg::PEC_SELA_BIT]; // R19
          st_next.inh_user = wr_val[pec_pkg::PEC_KU_BIT];
          st_next.cnt_c = wr_val[29:16]; // R19
          st_next.ctl_a = wr_val[15:14];
          st_next.ctl_b = wr_val[13:12];
          st_next.ctl_c = wr_val[11:10];
          st_next.inh_privlib = wr_val[pec_pkg::PEC_KP_BIT];
          st_next.inh_os = wr_val[pec_pkg::PEC_KK_BIT];
          st_next.sel_b = wr_val[7:4];
          st_next.sel_c = wr_val[3:0];
        end
        pec_pkg::PEC_CTR_HI_OFF: begin
          st_next.cnt_a = wr_val[31:16]; // R19
          st_next.cnt_b = wr_val[15:0];
        end
        pec_pkg::PEC_CLEAR_OFF: ;
        pec_pkg::PEC_MASK_OFF: st_next.mask = wr_val[2:0];
        pec_pkg::PEC_MASTER_OFF: st_next.master_en = wr_val[1:0];
        pec_pkg::PEC_SUMMARY_OFF: ;
        default: st_next.bresp = 2'b10; // unmapped: slverr
      endcase
    end
    // sticky pending: clear by write-one, new hit wins
    if (do_write && st_reg.aw_addr == pec_pkg::PEC_CLEAR_OFF) begin
      st_next.pend = st_reg.pend & ~(st_reg.w_data[29:27] & {3{st_reg.w_strb[3]}}); // R17
    end
    st_next.pend = st_next.pend | hit; // R18
    st_next.irq = |(st_next.pend & st_next.mask);
    // response retire
    if (st_reg.wph == pec_pkg::PEC_W_RESP && s_axi_bready) begin
      st_next.bvalid = 1'b0;
      st_next.aw_got = 1'b0;
      st_next.w_got = 1'b0;
      st_next.wph = pec_pkg::PEC_W_IDLE;
    end
    // read channel: accept, answer next cycle
    st_next.arready = 1'b0;
    if (s_axi_arvalid && !st_reg.arready && !st_reg.rvalid) begin
      st_next.arready = 1'b1;
      st_next.rvalid = 1'b1;
      st_next.rresp = 2'b00;
      unique case ({s_axi_araddr[11:2], 2'b00})
        pec_pkg::PEC_CTR_LO_OFF: st_next.rdata = ctr_word[31:0];
        pec_pkg::PEC_CTR_HI_OFF: st_next.rdata = ctr_word[63:32];
        pec_pkg::PEC_SUMMARY_OFF: st_next.rdata = summary; // R15
        pec_pkg::PEC_CLEAR_OFF: st_next.rdata = '0; // write-only
        pec_pkg::PEC_MASK_OFF: st_next.rdata = {29'h0, st_reg.mask};
        pec_pkg::PEC_MASTER_OFF: st_next.rdata = {30'h0, st_reg.master_en};
        default: begin
          st_next.rdata = '0;
          st_next.rresp = 2'b10;
        end
      endcase
    end
    if (st_reg.rvalid && s_axi_rready) st_next.rvalid = 1'b0;
  end

  // single state register; controls clear at reset
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= '0; // R02 R03 R04
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from flip-flops
  assign s_axi_awready = !st_reg.aw_got;
  assign s_axi_wready = !st_reg.w_got;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = st_reg.arready;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;
  assign irq = st_reg.irq;

  // helper: pending latch of counter a at a 256 threshold
  property p_a256;
    @(posedge core_clk) disable iff (!resetn)
      (count_ok && ev_a && st_reg.ctl_a == pec_pkg::PEC_CTL_256 && st_reg.cnt_a[7:0] == 8'hff)
      |=> st_reg.pend[0];
  endproperty
  a_a256: assert property (p_a256) else $error("counter a 256 irq missing"); // R02
  property p_bfull;
    @(posedge core_clk) disable iff (!resetn)
      (count_ok && ev_b && !do_write && st_reg.ctl_b == pec_pkg::PEC_CTL_FULL
       && st_reg.cnt_b == 16'hffff) |=> (st_reg.cnt_b == 16'h0000 && st_reg.pend[1]);
  endproperty
  a_bfull: assert property (p_bfull) else $error("counter b wrap irq missing"); // R03
  property p_cfull;
    @(posedge core_clk) disable iff (!resetn)
      (count_ok && ev_c && st_reg.ctl_c == pec_pkg::PEC_CTL_FULL && st_reg.cnt_c == 14'h3fff)
      |=> st_reg.pend[2];
  endproperty
  a_cfull: assert property (p_cfull) else $error("counter c 16384 irq missing"); // R04
  property p_off;
    @(posedge core_clk) disable iff (!resetn)
      (st_reg.ctl_a == pec_pkg::PEC_CTL_OFF && !do_write) |=> $stable(st_reg.cnt_a);
  endproperty
  a_off: assert property (p_off) else $error("disabled counter a moved"); // R02
  property p_master;
    @(posedge core_clk) disable iff (!resetn)
      (st_reg.master_en == 2'b00 && !do_write) |=> $stable(st_reg.cnt_c);
  endproperty
  a_master: assert property (p_master) else $error("counting with master off"); // R16
  property p_user;
    @(posedge core_clk) disable iff (!resetn)
      (cpu_mode == pec_pkg::PEC_MODE_USER && st_reg.inh_user && !do_write)
      |=> $stable(st_reg.cnt_b);
  endproperty
  a_user: assert property (p_user) else $error("counted in inhibited user mode"); // R06
  property p_execall;
    @(posedge core_clk) disable iff (!resetn)
      (cpu_mode == pec_pkg::PEC_MODE_EXEC && st_reg.inh_user && st_reg.inh_privlib
       && st_reg.inh_os && st_reg.master_en != 2'b00) |-> count_ok;
  endproperty
  a_execall: assert property (p_execall) else $error("exec mode wrongly killed"); // R08
  property p_clear;
    @(posedge core_clk) disable iff (!resetn)
      (do_write && st_reg.aw_addr == pec_pkg::PEC_CLEAR_OFF && st_reg.w_strb[3]
       && st_reg.w_data[27] && !hit[0]) |=> !st_reg.pend[0];
  endproperty
  a_clear: assert property (p_clear) else $error("pending a not cleared"); // R17
  property p_load;
    @(posedge core_clk) disable iff (!resetn)
      (do_write && st_reg.aw_addr == pec_pkg::PEC_CTR_HI_OFF && st_reg.w_strb == 4'hf)
      |=> st_reg.cnt_a == $past(st_reg.w_data[31:16]);
  endproperty
  a_load: assert property (p_load) else $error("software load lost"); // R19
  // irq must fall once the last unmasked pending bit is cleared and nothing new hits
  property p_irq;
    @(posedge core_clk) disable iff (!resetn)
      (do_write && st_reg.aw_addr == pec_pkg::PEC_CLEAR_OFF && st_reg.w_strb[3] && hit == 3'b000
       && (st_reg.pend & st_reg.mask & ~st_reg.w_data[29:27]) == 3'b000) |=> !irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq held after clear"); // R17
  // software clear seen on the bus
  c_clr: cover property (@(posedge core_clk) disable iff (!resetn)
    do_write && st_reg.aw_addr == pec_pkg::PEC_CLEAR_OFF);
  c_wr: cover property (@(posedge core_clk) disable iff (!resetn) do_write);
  c_hit: cover property (@(posedge core_clk) disable iff (!resetn) |hit);
  c_irq: cover property (@(posedge core_clk) disable iff (!resetn) $rose(irq));
  c_rd: cover property (@(posedge core_clk) disable iff (!resetn) st_reg.rvalid);
endmodule : pec_top

/* tb/pec_src.sv */
/*
  event source model: replays one event vector for a set number of
  cycles after a go pulse and follows the requested cpu mode.
  assumes go is a one-cycle pulse and n_ev is at least one.
*/
`timescale 1ns/10ps
module pec_src (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic go,
  input wire logic [7:0] n_ev,
  input wire logic [30:0] ev_req,
  input wire pec_pkg::pec_mode_t mode_req,
  output pec_pkg::pec_events_t events,
  output pec_pkg::pec_mode_t cpu_mode
);
  logic [7:0] left_reg; // event cycles still to send
  // events change just after an edge; all low when idle means no events
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      events <= '0;
      cpu_mode <= pec_pkg::PEC_MODE_KERNEL;
      left_reg <= 8'h00;
    end else begin
      cpu_mode <= mode_req; // mode follows the request one edge later
      if (go) begin
        events <= ev_req;
        left_reg <= n_ev - 8'h01;
      end else if (left_reg != 8'h00) begin
        left_reg <= left_reg - 8'h01;
      end else begin
        events <= '0;
      end
    end
  end
endmodule : pec_src

/* tb/tb.sv */
/*
  self-checking bench for the event counter block: reset and master
  enable tests, a table of select cases, then inhibit, interrupt, bus and reset tests.
  assumes pec_src drives events and mode; registers reached over axi4-lite.
*/
`timescale 1ns/10ps
module tb;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf; // full words only
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, lo, hi, lo2, hi2;
  pec_pkg::pec_events_t events;
  pec_pkg::pec_mode_t cpu_mode;
  logic go = 1'b0;
  logic [7:0] n_ev = 8'h03; // three events per burst
  logic [30:0] ev_req = 31'h0;
  pec_pkg::pec_mode_t mode_req = pec_pkg::PEC_MODE_KERNEL;
  logic ok;
  int num_errors = 0;
  int tests_run = 0;
  // one select case: selects, event vector, expected b and c counts
  typedef struct {logic [3:0] sb; logic [3:0] sc; logic [30:0] ev; logic [15:0] eb;
    logic [15:0] ec;} pec_row_t;
  pec_row_t rows [19];
  logic [11:0] offs [6];

  pec_top DUT (.core_clk(core_clk), .resetn(resetn), .events(events), .cpu_mode(cpu_mode),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .irq(irq));
  pec_src src (.core_clk(core_clk), .resetn(resetn), .go(go), .n_ev(n_ev), .ev_req(ev_req),
    .mode_req(mode_req), .events(events), .cpu_mode(cpu_mode));

  // 100 mhz core clock
  initial begin
    forever #5 core_clk = ~core_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up

  // one clock of a bus wait; a hung slave ends the run
  task automatic tick(inout int n);
    @(posedge core_clk);
    n++;
    if (n > 200) begin
      num_errors++;
      $display("MISMATCH t=%0t bus answer never came", $time);
      wrap_up();
    end
  endtask : tick

  // write: address and data offered together, each dropped when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      tick(n);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        resp = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      tick(n);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : rd

  // one burst of three event cycles, then let the counts settle
  task automatic pulse(input logic [30:0] ev, input pec_pkg::pec_mode_t m);
    @(posedge core_clk);
    ev_req <= ev;
    mode_req <= m;
    go <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
    repeat (6) @(posedge core_clk);
  endtask : pulse

  // low word image: sel_a, inhibits, count_c, controls, selects
  function automatic logic [31:0] lw(logic sa, logic ku, logic [13:0] c, logic [1:0] ca,
    logic [1:0] cb, logic [1:0] cc, logic kp, logic kk, logic [3:0] sb, logic [3:0] sc);
    return {sa, ku, c, ca, cb, cc, kp, kk, sb, sc};
  endfunction : lw

  initial begin
    rows[0] = '{4'h0, 4'h0, 31'h60002000, 16'h3, 16'h3};
    rows[1] = '{4'h1, 4'h2, 31'h10001000, 16'h3, 16'h3};
    rows[2] = '{4'h2, 4'h3, 31'h08000800, 16'h3, 16'h3};
    rows[3] = '{4'h3, 4'h4, 31'h04000400, 16'h3, 16'h3};
    rows[4] = '{4'h4, 4'h5, 31'h00800200, 16'h3, 16'h3};
    rows[5] = '{4'h5, 4'h6, 31'h01000100, 16'h3, 16'h3};
    rows[6] = '{4'h6, 4'h7, 31'h01800080, 16'h3, 16'h3};
    rows[7] = '{4'h7, 4'h8, 31'h01800040, 16'h0, 16'h3};
    rows[8] = '{4'h9, 4'h9, 31'h00080020, 16'h3, 16'h3};
    rows[9] = '{4'ha, 4'ha, 31'h00040010, 16'h3, 16'h3};
    rows[10] = '{4'hb, 4'hd, 31'h00020008, 16'h3, 16'h3};
    rows[11] = '{4'hc, 4'he, 31'h00010004, 16'h3, 16'h3};
    rows[12] = '{4'hd, 4'h1, 31'h0000bffc, 16'h3, 16'h0};
    rows[13] = '{4'he, 4'hb, 31'h00007ffc, 16'h3, 16'h0};
    rows[14] = '{4'hf, 4'hf, 31'h00000003, 16'h3, 16'h3};
    rows[15] = '{4'h8, 4'h4, 31'h00100400, 16'h3, 16'h3};
    rows[16] = '{4'h8, 4'h2, 31'h00401000, 16'h3, 16'h3};
    rows[17] = '{4'h8, 4'h2, 31'h00301000, 16'h0, 16'h3};
    rows[18] = '{4'h8, 4'h3, 31'h00500800, 16'h0, 16'h3};
    offs = '{pec_pkg::PEC_CTR_LO_OFF, pec_pkg::PEC_CTR_HI_OFF, pec_pkg::PEC_SUMMARY_OFF,
      pec_pkg::PEC_CLEAR_OFF, pec_pkg::PEC_MASK_OFF, pec_pkg::PEC_MASTER_OFF};
    repeat (20) @(posedge core_clk);
    resetn <= 1'b1;
    // every register reads zero after reset
    foreach (offs[i]) begin
      rd(offs[i], lo);
      chk(lo, 32'h0);
    end
    $display("test reset values done");
    // nothing counts until the master enable is set
    wr(pec_pkg::PEC_CTR_LO_OFF, lw(1'b0, 1'b0, 14'h0, 2'h0, 2'h1, 2'h0, 1'b0, 1'b0, 4'h0, 4'h0));
    pulse(31'h20000000, pec_pkg::PEC_MODE_KERNEL);
    rd(pec_pkg::PEC_CTR_HI_OFF, hi);
    chk(hi, 32'h0);
    wr(pec_pkg::PEC_MASTER_OFF, 32'h2);
    pulse(31'h20000000, pec_pkg::PEC_MODE_KERNEL);
    rd(pec_pkg::PEC_CTR_HI_OFF, hi);
    chk(hi, 32'h3);
    $display("test master enable done");
    // select table: every b select code, every c select code except c, coupling of code 8
    foreach (rows[i]) begin
      wr(pec_pkg::PEC_CTR_HI_OFF, 32'h0);
      wr(pec_pkg::PEC_CTR_LO_OFF,
        lw(1'b1, 1'b0, 14'h0, 2'h1, 2'h1, 2'h1, 1'b0, 1'b0, rows[i].sb, rows[i].sc));
      pulse(rows[i].ev, pec_pkg::PEC_MODE_KERNEL);
      rd(pec_pkg::PEC_CTR_HI_OFF, hi);
      rd(pec_pkg::PEC_CTR_LO_OFF, lo);
      chk({16'h0, hi[31:16]}, rows[i].ev[30] ? 32'h3 : 32'h0);
      chk({16'h0, hi[15:0]}, {16'h0, rows[i].eb});
      chk({18'h0, lo[29:16]}, {16'h0, rows[i].ec});
    end
    $display("test select table done");
    // every inhibit combination against every mode
    for (int k = 0; k < 8; k++) begin
      for (int m = 0; m < 5; m++) begin
        wr(pec_pkg::PEC_CTR_HI_OFF, 32'h0);
        wr(pec_pkg::PEC_CTR_LO_OFF,
          lw(1'b0, k[2], 14'h0, 2'h0, 2'h1, 2'h0, k[1], k[0], 4'h0, 4'h0));
        pulse(31'h20000000, pec_pkg::pec_mode_t'(m));
        rd(pec_pkg::PEC_CTR_HI_OFF, hi);
        ok = (m == 3) ? !k[2] : (m == 4) ? !k[1] : (!k[0] || (m != 0 && k[2] && k[1]));
        chk(hi, ok ? 32'h3 : 32'h0);
      end
    end
    $display("test inhibits done");
    // thresholds: a at 256 on instructions, b and c full wraps
    wr(pec_pkg::PEC_CTR_HI_OFF, 32'h00fffffd);
    wr(pec_pkg::PEC_CTR_LO_OFF,
      lw(1'b1, 1'b0, 14'h3ffe, 2'h3, 2'h2, 2'h2, 1'b0, 1'b0, 4'h0, 4'h0));
    pulse(31'h60002000, pec_pkg::PEC_MODE_KERNEL);
    rd(pec_pkg::PEC_SUMMARY_OFF, lo);
    chk(lo, 32'h38000000);
    rd(pec_pkg::PEC_CTR_HI_OFF, hi);
    chk({16'h0, hi[15:0]}, 32'h0);
    chk({16'h0, hi[31:16]}, 32'h102);
    rd(pec_pkg::PEC_CTR_LO_OFF, lo);
    chk({18'h0, lo[29:16]}, 32'h1);
    chk({31'h0, irq}, 32'h0); // all masked, no interrupt
    wr(pec_pkg::PEC_MASK_OFF, 32'h2);
    chk({31'h0, irq}, 32'h1);
    wr(pec_pkg::PEC_CLEAR_OFF, 32'h10000000);
    chk({31'h0, irq}, 32'h0);
    rd(pec_pkg::PEC_SUMMARY_OFF, lo);
    chk(lo, 32'h28000000);
    wr(pec_pkg::PEC_CLEAR_OFF, 32'h28000000);
    rd(pec_pkg::PEC_SUMMARY_OFF, lo);
    chk(lo, 32'h0);
    $display("test interrupts done");
    // unmapped address answers with an error
    wr(12'h200, 32'hffffffff);
    chk({30'h0, resp}, 32'h2);
    rd(12'h200, lo);
    chk({30'h0, resp}, 32'h2);
    chk(lo, 32'h0);
    $display("test unmapped done");
    // cycle selects count with no event; either master bit enables
    wr(pec_pkg::PEC_MASTER_OFF, 32'h1);
    wr(pec_pkg::PEC_CTR_LO_OFF,
      lw(1'b0, 1'b0, 14'h0, 2'h1, 2'h0, 2'h1, 1'b0, 1'b0, 4'h0, 4'hc));
    rd(pec_pkg::PEC_CTR_HI_OFF, hi);
    rd(pec_pkg::PEC_CTR_LO_OFF, lo);
    rd(pec_pkg::PEC_CTR_HI_OFF, hi2);
    rd(pec_pkg::PEC_CTR_LO_OFF, lo2);
    chk({31'h0, hi2[31:16] > hi[31:16]}, 32'h1);
    chk({31'h0, lo2[29:16] > lo[29:16]}, 32'h1);
    $display("test cycle selects done");
    // reset in mid-run: everything back to zero, bus ready again
    @(posedge core_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    chk({29'h0, awready, wready, irq}, 32'h6);
    foreach (offs[i]) begin
      rd(offs[i], lo);
      chk(lo, 32'h0);
    end
    $display("test mid-run reset done");
    wrap_up();
  end
endmodule : tb
